/* File: pkg/acc_defs.vh */
// register offsets, field positions and codes of the adc channel control
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH

// printed offsets are indices; byte address is four times the index
`define ACC_IDX_CTRL      2'h0
`define ACC_IDX_MUX       2'h1
`define ACC_IDX_IRQ       2'h2
`define ACC_IDX_AUX       2'h3

// channel_control fields
`define ACC_CTRL_START    7
`define ACC_CTRL_MASK     8'h9F
`define ACC_MUX_MASK      8'h7F
`define ACC_IRQ_MASK      8'h0F

// aux register: bit0 signed conversion, bits 31:16 threshold, bit8 flag
`define ACC_AUX_SIGNED    0
`define ACC_AUX_FLAG      8

// source kinds
`define ACC_SRC_INTERNAL  2'h0
`define ACC_SRC_SINGLE    2'h1
`define ACC_SRC_DIFF      2'h2
`define ACC_SRC_DIFFAMP   2'h3

// irq conditions
`define ACC_IRQ_COMPLETE  2'h0
`define ACC_IRQ_BELOW     2'h1
`define ACC_IRQ_ABOVE     2'h3

// route classes driven to the analog side
`define ACC_RT_NONE       2'h0
`define ACC_RT_INTERNAL   2'h1
`define ACC_RT_PIN        2'h2

// negative route codes
`define ACC_NEG_PIN       2'h0
`define ACC_NEG_PADGND    2'h1
`define ACC_NEG_INTERNAL_GROUND_REF    2'h2
`define ACC_NEG_NONE      2'h3

`define ACC_RESET_BYTE    8'h00
`define ACC_RESET_WORD    16'h0000

`endif

/* File: hdl/acc_route_decode.v */
// decodes channel mode and mux codes into analog routing and gain use
`default_nettype none
`include "acc_defs.vh"

module acc_route_decode (
  input  wire       signed_mode_in,
  input  wire [1:0] source_kind_select_in,
  input  wire [3:0] positive_input_select_in,
  input  wire [2:0] negative_input_select_in,
  output reg  [1:0] pos_route_out,
  output reg  [3:0] pos_index_out,
  output reg  [1:0] neg_route_out,
  output reg  [2:0] neg_index_out,
  output reg        gain_used_out,
  output reg        config_legal_out
);

  // purely combinational; reserved codes route nowhere
  always @* begin
    pos_route_out    = `ACC_RT_NONE;
    pos_index_out    = positive_input_select_in;
    neg_route_out    = `ACC_NEG_NONE;
    neg_index_out    = 3'h0;
    gain_used_out    = 1'b0;
    config_legal_out = 1'b0;
    case (source_kind_select_in)
      `ACC_SRC_INTERNAL: begin
        if (positive_input_select_in[3:2] == 2'h0) begin
          pos_route_out    = `ACC_RT_INTERNAL;
          config_legal_out = 1'b1;
        end
      end
      `ACC_SRC_SINGLE: begin
        pos_route_out    = `ACC_RT_PIN;
        config_legal_out = 1'b1;
      end
      `ACC_SRC_DIFF: begin
        if (signed_mode_in) begin
          pos_route_out = `ACC_RT_PIN;
          if (!negative_input_select_in[2]) begin
            neg_route_out    = `ACC_NEG_PIN;
            neg_index_out    = negative_input_select_in;
            config_legal_out = 1'b1;
          end else if (negative_input_select_in == 3'h5) begin
            neg_route_out    = `ACC_NEG_PADGND;
            config_legal_out = 1'b1;
          end else if (negative_input_select_in == 3'h7) begin
            neg_route_out    = `ACC_NEG_INTERNAL_GROUND_REF;
            config_legal_out = 1'b1;
          end
        end
      end
      default: begin
        // differential with gain, legal only in signed mode
        if (signed_mode_in && !positive_input_select_in[3]) begin
          pos_route_out = `ACC_RT_PIN;
          gain_used_out = 1'b1;
          if (!negative_input_select_in[2]) begin
            neg_route_out    = `ACC_NEG_PIN;
            neg_index_out    = {1'b1, negative_input_select_in[1:0]};
            config_legal_out = 1'b1;
          end else if (negative_input_select_in == 3'h4) begin
            neg_route_out    = `ACC_NEG_INTERNAL_GROUND_REF;
            config_legal_out = 1'b1;
          end else if (negative_input_select_in == 3'h7) begin
            neg_route_out    = `ACC_NEG_PADGND;
            config_legal_out = 1'b1;
          end
        end
      end
    endcase
    if (!config_legal_out) begin
      pos_route_out = `ACC_RT_NONE;
      neg_route_out = `ACC_NEG_NONE;
      gain_used_out = 1'b0;
    end
  end

endmodule // acc_route_decode
`default_nettype wire

/* File: hdl/acc_compare.v */
// threshold compare of a finished result, signed or unsigned
`default_nettype none

module acc_compare #(
  parameter WIDTH = 16
) (
  input  wire [WIDTH-1:0] result_in,
  input  wire [WIDTH-1:0] threshold_in,
  input  wire             signed_mode_in,
  output wire             below_out,
  output wire             above_out
);

  wire signed [WIDTH-1:0] res_s = result_in;
  wire signed [WIDTH-1:0] thr_s = threshold_in;

  // two's complement view in signed mode
  assign below_out = signed_mode_in ? (res_s < thr_s)
                                    : (result_in < threshold_in);
  assign above_out = signed_mode_in ? (res_s > thr_s)
                                    : (result_in > threshold_in);

endmodule // acc_compare
`default_nettype wire

/* File: hdl/acc_channel_top.v */
// adc channel control registers with ahb-lite slave and core handshake
// Behaviour
// - writing one to control bit 7 starts a conversion on this channel
// - the start bit clears itself once the core accepts the conversion
// - rewriting start while set does nothing and queues nothing
// - start bit shares storage with this channel's global kick bit
// - three-bit gain selects 1x to 64x, code seven selects one half
// - gain applies only to the differential with gain configuration
// - changing source kind may spoil conversions already in flight
// - unsigned mode: internal and single pin, codes two and three reserved
// - signed mode adds differential and amplified differential inputs
// - internal mode: temperature, bandgap, supply tenth, dac, rest reserved
// - single pin or differential: positive code selects that pin
// - amplified differential: positive codes zero to seven, rest reserved
// - negative select is ignored for internal and single pin modes
// - differential: pins zero to three, five pad ground, seven internal
// - amplified: pins four to seven, four internal, seven pad ground
// - irq condition: complete, below, above; code two reserved
// - priority level enables the irq, which requests while the flag is set
// - flag sets on complete or met compare, clears on vector or write one
// - in signed mode the threshold is two's complement
`default_nettype none
`include "acc_defs.vh"

module acc_channel_top #(
  parameter RES_WIDTH = 16
) (
  input  wire                 clk_in,
  input  wire                 srst_in,
  // ahb-lite slave
  input  wire                 hsel_in,
  input  wire [31:0]          haddr_in,
  input  wire [1:0]           htrans_in,
  input  wire                 hwrite_in,
  input  wire [2:0]           hsize_in,
  input  wire [31:0]          hwdata_in,
  input  wire                 hready_in,
  output wire [31:0]          hrdata_out,
  output wire                 hreadyout_out,
  output wire                 hresp_out,
  // global kick bit path from the converter main control
  input  wire                 global_kick_wr_in,
  input  wire                 global_kick_val_in,
  output wire                 global_kick_out,
  // converter core
  input  wire                 conv_accept_in,
  input  wire                 conv_done_in,
  input  wire [RES_WIDTH-1:0] conv_result_in,
  output wire                 conv_request_out,
  output wire                 pipeline_flush_out,
  output reg  [2:0]           gain_code_out,
  output reg                  gain_enable_out,
  output reg  [1:0]           pos_route_out,
  output reg  [3:0]           pos_index_out,
  output reg  [1:0]           neg_route_out,
  output reg  [2:0]           neg_index_out,
  output reg                  config_legal_out,
  // interrupt controller side
  input  wire                 vector_ack_in,
  output wire [1:0]           irq_priority_level_out,
  output wire                 irq_request_out
);

  // one-hot-free register storage
  reg        start_q;
  reg  [2:0] gain_q;
  reg  [1:0] source_kind_q;
  reg  [3:0] pos_sel_q;
  reg  [2:0] neg_sel_q;
  reg  [1:0] irq_cond_q;
  reg  [1:0] irq_level_q;
  reg        signed_q;
  reg  [RES_WIDTH-1:0] threshold_q;
  reg        flag_q;
  reg        flush_q;
  reg  [1:0] wr_idx_q;
  reg        wr_pend_q;
  reg  [31:0] rdata_q;

  // decode helper shared by read and write phases
  function [1:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[3:2];
    end
  endfunction

  function addr_mapped;
    input [31:0] addr;
    begin
      addr_mapped = (addr[31:4] == 28'h0000000) && (addr[1:0] == 2'h0);
    end
  endfunction

  wire addr_ok = hsel_in && hready_in && htrans_in[1];
  wire wr_take = addr_ok && hwrite_in && addr_mapped(haddr_in);
  wire rd_take = addr_ok && !hwrite_in;

  // zero wait states, always okay
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = rdata_q;

  wire wr_ctrl = wr_pend_q && (wr_idx_q == `ACC_IDX_CTRL);
  wire wr_mux  = wr_pend_q && (wr_idx_q == `ACC_IDX_MUX);
  wire wr_irq  = wr_pend_q && (wr_idx_q == `ACC_IDX_IRQ);
  wire wr_aux  = wr_pend_q && (wr_idx_q == `ACC_IDX_AUX);

  // address phase capture for the following write data phase
  always @(posedge clk_in) begin
    if (srst_in) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 2'h0;
    end else begin
      wr_pend_q <= wr_take;
      if (wr_take) begin
        wr_idx_q <= reg_index(haddr_in);
      end
    end
  end

  // start bit: one storage reached by both locations
  wire sw_start_set = wr_ctrl && hwdata_in[`ACC_CTRL_START];
  wire gl_start_set = global_kick_wr_in && global_kick_val_in;
  always @(posedge clk_in) begin
    if (srst_in) begin
      start_q <= 1'b0;
    end else if (start_q && conv_accept_in) begin
      start_q <= 1'b0;
    end else if (sw_start_set || gl_start_set) begin
      start_q <= 1'b1;
    end
  end
  // a set arriving with accept is the same request, so accept wins here
  assign conv_request_out = start_q;
  assign global_kick_out  = start_q;

  // configuration fields; reserved bits are not stored
  always @(posedge clk_in) begin
    if (srst_in) begin
      gain_q        <= 3'h0;
      source_kind_q <= 2'h0;
      pos_sel_q     <= 4'h0;
      neg_sel_q     <= 3'h0;
      irq_cond_q    <= 2'h0;
      irq_level_q   <= 2'h0;
      signed_q      <= 1'b0;
      threshold_q   <= `ACC_RESET_WORD;
    end else begin
      if (wr_ctrl) begin
        gain_q        <= hwdata_in[4:2];
        source_kind_q <= hwdata_in[1:0];
      end
      if (wr_mux) begin
        pos_sel_q <= hwdata_in[6:3];
        neg_sel_q <= hwdata_in[2:0];
      end
      if (wr_irq) begin
        irq_cond_q  <= hwdata_in[3:2];
        irq_level_q <= hwdata_in[1:0];
      end
      if (wr_aux) begin
        signed_q    <= hwdata_in[`ACC_AUX_SIGNED];
        threshold_q <= hwdata_in[31:16];
      end
    end
  end

  // changing source kind flushes results in flight for one cycle
  always @(posedge clk_in) begin
    if (srst_in) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= wr_ctrl && (hwdata_in[1:0] != source_kind_q);
    end
  end
  assign pipeline_flush_out = flush_q;

  // routing decode of the stored selects
  wire [1:0] dec_pos_route;
  wire [3:0] dec_pos_index;
  wire [1:0] dec_neg_route;
  wire [2:0] dec_neg_index;
  wire       dec_gain_used;
  wire       dec_legal;

  acc_route_decode u_decode (
    .signed_mode_in           (signed_q),
    .source_kind_select_in    (source_kind_q),
    .positive_input_select_in (pos_sel_q),
    .negative_input_select_in (neg_sel_q),
    .pos_route_out            (dec_pos_route),
    .pos_index_out            (dec_pos_index),
    .neg_route_out            (dec_neg_route),
    .neg_index_out            (dec_neg_index),
    .gain_used_out            (dec_gain_used),
    .config_legal_out         (dec_legal)
  );

  // registered routing outputs to the analog side
  always @(posedge clk_in) begin
    if (srst_in) begin
      gain_code_out    <= 3'h0;
      gain_enable_out  <= 1'b0;
      pos_route_out    <= `ACC_RT_NONE;
      pos_index_out    <= 4'h0;
      neg_route_out    <= `ACC_NEG_NONE;
      neg_index_out    <= 3'h0;
      config_legal_out <= 1'b0;
    end else begin
      gain_code_out    <= dec_gain_used ? gain_q : 3'h0;
      gain_enable_out  <= dec_gain_used;
      pos_route_out    <= dec_pos_route;
      pos_index_out    <= dec_pos_index;
      neg_route_out    <= dec_neg_route;
      neg_index_out    <= dec_neg_index;
      config_legal_out <= dec_legal;
    end
  end

  // threshold compare of the arriving result
  wire cmp_below;
  wire cmp_above;

  acc_compare #(
    .WIDTH (RES_WIDTH)
  ) u_compare (
    .result_in      (conv_result_in),
    .threshold_in   (threshold_q),
    .signed_mode_in (signed_q),
    .below_out      (cmp_below),
    .above_out      (cmp_above)
  );

  reg flag_event;
  always @* begin
    flag_event = 1'b0;
    if (conv_done_in) begin
      if (irq_cond_q == `ACC_IRQ_COMPLETE) begin
        flag_event = 1'b1;
      end else if (irq_cond_q == `ACC_IRQ_BELOW) begin
        flag_event = cmp_below;
      end else if (irq_cond_q == `ACC_IRQ_ABOVE) begin
        flag_event = cmp_above;
      end
    end
  end

  // flag: set wins over a clear in the same cycle
  wire flag_clear = vector_ack_in || (wr_aux && hwdata_in[`ACC_AUX_FLAG]);
  always @(posedge clk_in) begin
    if (srst_in) begin
      flag_q <= 1'b0;
    end else if (flag_event) begin
      flag_q <= 1'b1;
    end else if (flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  assign irq_priority_level_out = irq_level_q;
  assign irq_request_out = flag_q && (irq_level_q != 2'h0);

  // read data registered at the address phase, shown in the data phase
  always @(posedge clk_in) begin
    if (srst_in) begin
      rdata_q <= 32'h00000000;
    end else if (rd_take) begin
      rdata_q <= 32'h00000000;
      if (!addr_mapped(haddr_in)) begin
        rdata_q <= 32'h00000000;
      end else if (reg_index(haddr_in) == `ACC_IDX_CTRL) begin
        rdata_q[7:0] <= {start_q, 2'h0, gain_q, source_kind_q};
      end else if (reg_index(haddr_in) == `ACC_IDX_MUX) begin
        rdata_q[7:0] <= {1'b0, pos_sel_q, neg_sel_q};
      end else if (reg_index(haddr_in) == `ACC_IDX_IRQ) begin
        rdata_q[7:0] <= {4'h0, irq_cond_q, irq_level_q};
      end else begin
        rdata_q <= {threshold_q, 7'h00, flag_q, 7'h00, signed_q};
      end
    end
  end

endmodule // acc_channel_top
`default_nettype wire

/* File: sim/acc_channel_asserts.sv */
// concurrent checks on the adc channel control ports
`default_nettype none
`include "acc_defs.vh"

module acc_channel_asserts (
  input wire logic       clk_in,
  input wire logic       srst_in,
  input wire logic       global_kick_wr_in,
  input wire logic       global_kick_val_in,
  input wire logic       global_kick_out,
  input wire logic       conv_accept_in,
  input wire logic       conv_done_in,
  input wire logic       conv_request_out,
  input wire logic       pipeline_flush_out,
  input wire logic       gain_enable_out,
  input wire logic [1:0] pos_route_out,
  input wire logic [3:0] pos_index_out,
  input wire logic [1:0] neg_route_out,
  input wire logic       config_legal_out,
  input wire logic       vector_ack_in,
  input wire logic [1:0] irq_priority_level_out,
  input wire logic       irq_request_out
);
  // single clock domain, so reset masks every check
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  start_clear_a:
    assert property (conv_request_out && conv_accept_in |=> !conv_request_out)
    else $error("start bit kept after core accept");
  kick_set_a:
    assert property (global_kick_wr_in && global_kick_val_in &&
      !conv_accept_in |=> conv_request_out)
    else $error("kick write did not raise request");
  same_store_a:
    assert property (global_kick_out == conv_request_out)
    else $error("kick bit and start bit differ");
  vector_clear_a:
    assert property (vector_ack_in && !conv_done_in |=> !irq_request_out)
    else $error("flag survived vector ack");
  irq_level_a:
    assert property (irq_request_out |-> irq_priority_level_out != 2'h0)
    else $error("irq request with level zero");
  gain_route_a:
    assert property (gain_enable_out |-> config_legal_out &&
      pos_route_out == `ACC_RT_PIN && !pos_index_out[3])
    else $error("gain used outside amplified pins 0..7");
  internal_idx_a:
    assert property (pos_route_out == `ACC_RT_INTERNAL |->
      pos_index_out <= 4'h3)
    else $error("reserved internal source routed");
  neg_ignore_a:
    assert property (pos_route_out == `ACC_RT_INTERNAL |->
      neg_route_out == `ACC_NEG_NONE)
    else $error("negative input used in internal mode");
  flush_pulse_a:
    assert property (pipeline_flush_out |=> !pipeline_flush_out)
    else $error("flush longer than one cycle");
  illegal_off_a:
    assert property (!config_legal_out |->
      pos_route_out == `ACC_RT_NONE && !gain_enable_out)
    else $error("reserved setting still routed");
endmodule // acc_channel_asserts

bind acc_channel_top acc_channel_asserts acc_channel_asserts_inst (
  .clk_in(clk_in), .srst_in(srst_in),
  .global_kick_wr_in(global_kick_wr_in),
  .global_kick_val_in(global_kick_val_in),
  .global_kick_out(global_kick_out), .conv_accept_in(conv_accept_in),
  .conv_done_in(conv_done_in), .conv_request_out(conv_request_out),
  .pipeline_flush_out(pipeline_flush_out),
  .gain_enable_out(gain_enable_out), .pos_route_out(pos_route_out),
  .pos_index_out(pos_index_out), .neg_route_out(neg_route_out),
  .config_legal_out(config_legal_out), .vector_ack_in(vector_ack_in),
  .irq_priority_level_out(irq_priority_level_out),
  .irq_request_out(irq_request_out)
);
`default_nettype wire

/* File: sim/acc_core_model.sv */
// behavioural converter core answering the channel start request
`default_nettype none

module acc_core_model (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        request_in,
  input  wire logic [3:0]  delay_in,
  input  wire logic [15:0] result_val_in,
  output logic             accept_out,
  output logic             done_out,
  output wire logic [15:0] result_out
);
  logic [3:0] cnt_q;
  logic [1:0] busy_q;

  // result bus is only meaningful with done; otherwise show junk
  assign result_out = done_out ? result_val_in : ~result_val_in;

  // accept after delay_in cycles, finish two cycles later
  always @(posedge clk_in) begin
    accept_out <= 1'b0;
    done_out <= 1'b0;
    if (srst_in) begin
      cnt_q <= 4'h0;
      busy_q <= 2'h0;
    end else if (busy_q != 2'h0) begin
      busy_q <= busy_q - 2'h1;
      done_out <= (busy_q == 2'h1);
    end else if (request_in && !accept_out) begin
      if (cnt_q == delay_in) begin
        accept_out <= 1'b1;
        cnt_q <= 4'h0;
        busy_q <= 2'h2;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule // acc_core_model
`default_nettype wire

/* File: sim/acc_channel_bench.sv */
// self-checking bench for the adc channel control block
`default_nettype none
`include "acc_defs.vh"
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %0h got %0h", nm, e, s); end end

module acc_channel_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        hsel = 1'b0, hwrite = 1'b0, kwr = 1'b0, kval = 1'b0;
  logic        vack = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [3:0]  dly = 4'h0;
  logic [15:0] res = 16'h0000;
  wire  [31:0] hrdata;
  wire  [15:0] result;
  wire  [3:0]  pidx;
  wire  [2:0]  gcode, nidx;
  wire  [1:0]  proute, nroute, lvl;
  wire         hrdy, hresp, kout, acc, done, req, flush, gen, legal, irq;
  int          n_mismatch = 0, checks_done = 0, n_acc = 0, n_flush = 0;

  acc_channel_top acc_channel_top_inst (
    .clk_in(clk_in), .srst_in(srst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp), .global_kick_wr_in(kwr),
    .global_kick_val_in(kval), .global_kick_out(kout),
    .conv_accept_in(acc), .conv_done_in(done), .conv_result_in(result),
    .conv_request_out(req), .pipeline_flush_out(flush),
    .gain_code_out(gcode), .gain_enable_out(gen), .pos_route_out(proute),
    .pos_index_out(pidx), .neg_route_out(nroute), .neg_index_out(nidx),
    .config_legal_out(legal), .vector_ack_in(vack),
    .irq_priority_level_out(lvl), .irq_request_out(irq));

  acc_core_model acc_core_model_inst (
    .clk_in(clk_in), .srst_in(srst_in), .request_in(req), .delay_in(dly),
    .result_val_in(res), .accept_out(acc), .done_out(done),
    .result_out(result));

  // 40 mhz clock
  always #12.5 clk_in = ~clk_in;

  // count core accepts and flush pulses
  always @(posedge clk_in) begin
    if (acc === 1'b1) n_acc <= n_acc + 1;
    if (flush === 1'b1) n_flush <= n_flush + 1;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one ahb-lite single word transfer; waits on hready, never on a count
  task automatic bus(input logic wr, input logic [31:0] a, d);
    @(posedge clk_in);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [31:0] a, e, input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  task automatic t_regs;
    rchk(32'h00, 32'h0, "ctrl reset");
    rchk(32'h0C, 32'h0, "aux reset");
    bus(1'b1, 32'h00, 32'h7F);
    rchk(32'h00, 32'h1F, "ctrl reserved");
    bus(1'b1, 32'h04, 32'h7F);
    rchk(32'h04, 32'h7F, "mux fields");
    bus(1'b1, 32'h08, 32'hFF);
    rchk(32'h08, 32'h0F, "irq reserved");
    bus(1'b1, 32'h10, 32'hFFFFFFFF);
    rchk(32'h10, 32'h0, "unmapped");
    `CHK("hresp okay", 1'b0, hresp)
    bus(1'b1, 32'h00, 32'h0);
    bus(1'b1, 32'h04, 32'h0);
    bus(1'b1, 32'h08, 32'h0);
    $display("test regs done");
  endtask

  // slow core so the rewrite lands while start is still set
  task automatic t_start;
    int a0;
    a0 = n_acc;
    dly <= 4'h8;
    bus(1'b1, 32'h00, 32'h80);
    @(posedge clk_in);
    `CHK("request", 1'b1, req)
    `CHK("kick mirror", 1'b1, kout)
    rchk(32'h00, 32'h80, "start read");
    bus(1'b1, 32'h00, 32'h80);
    repeat (20) @(posedge clk_in);
    `CHK("one accept", a0 + 1, n_acc)
    rchk(32'h00, 32'h0, "start cleared");
    dly <= 4'h0;
    kwr <= 1'b1;
    kval <= 1'b1;
    @(posedge clk_in);
    kwr <= 1'b0;
    @(posedge clk_in);
    `CHK("kick start", 1'b1, req)
    repeat (8) @(posedge clk_in);
    `CHK("kick accept", a0 + 2, n_acc)
    $display("test start done");
  endtask

  task automatic t_flush;
    int f0;
    f0 = n_flush;
    bus(1'b1, 32'h00, 32'h01);
    repeat (3) @(posedge clk_in);
    `CHK("flush", f0 + 1, n_flush)
    $display("test flush done");
  endtask

  // expected tuple: legal, gain use, pos route, pos index, neg route
  task automatic cfg(input logic [7:0] aux, ctl, mux, input logic [9:0] e,
                     input string nm);
    bus(1'b1, 32'h0C, {24'h0, aux});
    bus(1'b1, 32'h00, {24'h0, ctl});
    bus(1'b1, 32'h04, {24'h0, mux});
    repeat (2) @(posedge clk_in);
    `CHK(nm, e, {legal, gen, proute, legal ? {pidx, nroute} : 6'h0})
  endtask

  task automatic t_cfg;
    cfg(8'h01, 8'h18, 8'h08, {2'b10, 2'h1, 4'h1, 2'h3}, "bandgap");
    cfg(8'h01, 8'h00, 8'h20, 10'h0, "int rsv");
    cfg(8'h01, 8'h01, 8'h78, {2'b10, 2'h2, 4'hF, 2'h3}, "pin15");
    cfg(8'h01, 8'h02, 8'h4A, {2'b10, 2'h2, 4'h9, 2'h0}, "diff");
    `CHK("diff neg pin", 3'h2, nidx)
    cfg(8'h01, 8'h02, 8'h4D, {2'b10, 2'h2, 4'h9, 2'h1}, "diff pad");
    cfg(8'h01, 8'h02, 8'h4C, 10'h0, "diff rsv");
    cfg(8'h00, 8'h02, 8'h4A, 10'h0, "unsigned diff");
    cfg(8'h01, 8'h19, 8'h18, {2'b10, 2'h2, 4'h3, 2'h3}, "no gain");
    cfg(8'h01, 8'h1F, 8'h40, 10'h0, "amp rsv");
    cfg(8'h01, 8'h1F, 8'h3C, {2'b11, 2'h2, 4'h7, 2'h2}, "amp gnd");
    cfg(8'h01, 8'h1F, 8'h39, {2'b11, 2'h2, 4'h7, 2'h0}, "amp");
    `CHK("amp neg pin", 3'h5, nidx)
    for (int g = 0; g < 8; g++) begin
      bus(1'b1, 32'h00, {24'h0, 1'b0, 2'b00, g[2:0], 2'b11});
      repeat (2) @(posedge clk_in);
      `CHK("gain code", g[2:0], gcode)
    end
    $display("test cfg done");
  endtask

  task automatic conv(input logic [15:0] r);
    res <= r;
    bus(1'b1, 32'h00, 32'h80);
    do @(posedge clk_in); while (done !== 1'b1);
    repeat (2) @(posedge clk_in);
  endtask

  task automatic t_irq;
    bus(1'b1, 32'h0C, 32'h100);
    bus(1'b1, 32'h04, 32'h08);
    bus(1'b1, 32'h08, 32'h02);
    conv(16'h0123);
    `CHK("irq complete", 1'b1, irq)
    `CHK("irq level", 2'h2, lvl)
    rchk(32'h0C, 32'h100, "flag set");
    bus(1'b1, 32'h0C, 32'h100);
    rchk(32'h0C, 32'h0, "flag w1c");
    conv(16'h0123);
    vack <= 1'b1;
    @(posedge clk_in);
    vack <= 1'b0;
    @(posedge clk_in);
    `CHK("vector clear", 1'b0, irq)
    bus(1'b1, 32'h08, 32'h00);
    conv(16'h0123);
    `CHK("level off", 1'b0, irq)
    bus(1'b1, 32'h0C, 32'h00100101);
    bus(1'b1, 32'h08, 32'h06);
    conv(16'hFFF0);
    `CHK("signed below", 1'b1, irq)
    bus(1'b1, 32'h0C, 32'h00100100);
    conv(16'hFFF0);
    `CHK("unsigned below", 1'b0, irq)
    bus(1'b1, 32'h08, 32'h0E);
    conv(16'h0020);
    `CHK("above", 1'b1, irq)
    $display("test irq done");
  endtask

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    n_mismatch++;
    $display("[ERR] watchdog exp done got hang");
    finish_test;
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    t_regs;
    t_start;
    t_flush;
    t_cfg;
    t_irq;
    finish_test;
  end
endmodule // acc_channel_bench
`default_nettype wire
